// >>> pkg/hpc_defs.svh
// register offsets, field positions, reset values and timing counts of playback control
`ifndef HPC_DEFS_SVH
`define HPC_DEFS_SVH

`define HPC_ADDR_FIRE 8'h0c
`define HPC_ADDR_CFG 8'h0d
`define HPC_ADDR_LIVE 8'h0e
`define HPC_ADDR_SLOT_FIRST 8'h0f
`define HPC_ADDR_SLOT_LAST 8'h16
`define HPC_FIRE_BIT 0
`define HPC_INTERVAL_BIT 5
`define HPC_ATTEN_LSB 0
`define HPC_FIRE_RESET 8'h00
`define HPC_CFG_RESET 8'h00
`define HPC_LIVE_RESET 8'h7f
`define HPC_SLOT_RESET 8'h01
`define HPC_CLK_HZ 50000000
`define HPC_STEP_SLOW_MS 5
`define HPC_STEP_FAST_MS 1
`define HPC_WAIT_UNIT_MS 10
`define HPC_MS_CYCLES (`HPC_CLK_HZ / 1000)
`define HPC_STEP_SLOW_CYC (`HPC_STEP_SLOW_MS * `HPC_MS_CYCLES)
`define HPC_STEP_FAST_CYC (`HPC_STEP_FAST_MS * `HPC_MS_CYCLES)

`endif

// >>> pkg/hpc_pkg.sv
// types shared by the playback control block
package hpc_pkg;

  typedef enum logic [1:0] {
    HPC_MODE_LIVE = 2'h0,
    HPC_MODE_SEQ = 2'h1,
    HPC_MODE_DIAG = 2'h2,
    HPC_MODE_CAL = 2'h3
  } hpc_mode_t;

  // gray order along idle -> load -> play; live drive sits one bit away from idle
  typedef enum logic [1:0] {
    HPC_ST_IDLE = 2'b00,
    HPC_ST_LOAD = 2'b01,
    HPC_ST_PLAY = 2'b11,
    HPC_ST_LIVE = 2'b10
  } hpc_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hpc_req_t;

  typedef struct packed {
    logic start;
    logic [6:0] id;
    logic [7:0] amplitude;
  } hpc_effect_t;

endpackage : hpc_pkg

// >>> rtl/hpc_step_timer.sv
// interval divider: one-cycle step pulse every 5 ms or 1 ms
`timescale 1ns/1ps
`include "hpc_defs.svh"

module hpc_step_timer
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic run,
  input wire logic fast,
  // step enable
  output logic step
);

  typedef struct packed {
    logic [17:0] count;
    logic step;
  } hpc_timer_state_t;

  localparam logic [17:0] SLOW_LAST = 18'(`HPC_STEP_SLOW_CYC - 1);
  localparam logic [17:0] FAST_LAST = 18'(`HPC_STEP_FAST_CYC - 1);

  hpc_timer_state_t st;
  hpc_timer_state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.step = 1'b0;
    if (!run)
    begin
      next_st.count = 18'h0;
    end
    else if (st.count >= (fast ? FAST_LAST : SLOW_LAST))
    begin
      next_st.count = 18'h0;
      next_st.step = 1'b1;
    end
    else
    begin
      next_st.count = st.count + 18'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign step = st.step;

endmodule : hpc_step_timer

// >>> rtl/hpc_playback_ctrl.sv
// playback control registers: fire bit, interval, attenuation, live drive, sequencer walk
`timescale 1ns/1ps
`include "hpc_defs.svh"

module hpc_playback_ctrl
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register access from the serial interface
  input hpc_pkg::hpc_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // operating mode and external trigger
  input wire logic [1:0] mode,
  input wire logic trigger,
  // engine handshakes: calibration, diagnostics, effect player
  output logic cal_start,
  input wire logic cal_done,
  output logic diag_start,
  input wire logic diag_done,
  output hpc_pkg::hpc_effect_t effect,
  input wire logic effect_done,
  output logic abort,
  // library sample in, drive out
  input wire logic signed [7:0] library_sample,
  output logic signed [7:0] drive,
  output logic drive_valid,
  output logic step
);

  localparam int NSLOTS = 8;

  typedef struct packed {
    hpc_pkg::hpc_state_t fsm;
    hpc_pkg::hpc_mode_t run_mode;
    logic fire;
    logic interval_fast;
    logic [1:0] library_attenuation;
    logic [7:0] live_drive_amplitude;
    logic [NSLOTS-1:0][7:0] slot;
    logic [2:0] slot_idx;
    logic [6:0] wait_left;
    logic [3:0] ms_sub;
    logic waiting;
    hpc_pkg::hpc_effect_t effect;
    logic cal_start;
    logic diag_start;
    logic abort;
    logic [7:0] rdata;
    logic rvalid;
    logic signed [7:0] drive;
    logic drive_valid;
  } hpc_ctrl_state_t;

  hpc_ctrl_state_t st;
  hpc_ctrl_state_t next_st;
  logic step_pulse;
  logic fire_set;
  logic fire_clear;
  logic [7:0] cur_slot;
  logic [9:0] scaled;

  // =========================================================
  // step interval divider
  hpc_step_timer u_step
  (
    .clk(clk),
    .resetn(resetn),
    .run(st.fsm != hpc_pkg::HPC_ST_IDLE),
    .fast(st.interval_fast),
    .step(step_pulse)
  );

  // =========================================================
  // attenuation of library samples
  // limitation: the quarter steps truncate toward minus infinity, so small
  // negative samples floor one code lower than their positive mirror
  always_comb
  begin
    case (st.library_attenuation)
      2'h0: scaled = {library_sample[7], library_sample[7], library_sample} <<< 2;
      2'h1: scaled = 10'({library_sample[7], library_sample[7], library_sample} * 10'sd3);
      2'h2: scaled = {library_sample[7], library_sample[7], library_sample} <<< 1;
      2'h3: scaled = {library_sample[7], library_sample[7], library_sample};
      default: scaled = 10'h0;
    endcase
  end

  assign cur_slot = st.slot[st.slot_idx];
  assign fire_set = trigger
    || (req.wr && req.addr == `HPC_ADDR_FIRE && req.wdata[`HPC_FIRE_BIT]);
  assign fire_clear = req.wr && req.addr == `HPC_ADDR_FIRE && !req.wdata[`HPC_FIRE_BIT];
  // the trigger is taken as a level: a pin held high keeps asserting the fire bit,
  // and it outranks a clear written in the same cycle, so no abort follows then

  // =========================================================
  // register file and playback sequencing
  always_comb
  begin
    next_st = st;
    next_st.cal_start = 1'b0;
    next_st.diag_start = 1'b0;
    next_st.abort = 1'b0;
    next_st.effect.start = 1'b0;
    next_st.rvalid = req.rd;
    next_st.drive_valid = 1'b0;
    if (req.wr)
    begin
      case (req.addr)
        `HPC_ADDR_CFG:
        begin
          next_st.interval_fast = req.wdata[`HPC_INTERVAL_BIT];
          next_st.library_attenuation = req.wdata[`HPC_ATTEN_LSB +: 2];
        end
        `HPC_ADDR_LIVE: next_st.live_drive_amplitude = req.wdata;
        default:
        begin
          if (req.addr >= `HPC_ADDR_SLOT_FIRST && req.addr <= `HPC_ADDR_SLOT_LAST)
          begin
            next_st.slot[3'(req.addr - `HPC_ADDR_SLOT_FIRST)] = req.wdata;
          end
        end
      endcase
    end
    if (req.rd)
    begin
      case (req.addr)
        `HPC_ADDR_FIRE: next_st.rdata = {7'h0, st.fire};
        `HPC_ADDR_CFG: next_st.rdata = {2'h0, st.interval_fast, 3'h0, st.library_attenuation};
        `HPC_ADDR_LIVE: next_st.rdata = st.live_drive_amplitude;
        default:
        begin
          if (req.addr >= `HPC_ADDR_SLOT_FIRST && req.addr <= `HPC_ADDR_SLOT_LAST)
          begin
            next_st.rdata = st.slot[3'(req.addr - `HPC_ADDR_SLOT_FIRST)];
          end
          else
          begin
            next_st.rdata = 8'h00;
          end
        end
      endcase
    end
    case (st.fsm)
      hpc_pkg::HPC_ST_IDLE:
      begin
        if (fire_set)
        begin
          next_st.fire = 1'b1;
          next_st.run_mode = hpc_pkg::hpc_mode_t'(mode);
          next_st.slot_idx = 3'h0;
          next_st.waiting = 1'b0;
          case (hpc_pkg::hpc_mode_t'(mode))
            hpc_pkg::HPC_MODE_SEQ: next_st.fsm = hpc_pkg::HPC_ST_LOAD;
            hpc_pkg::HPC_MODE_LIVE: next_st.fsm = hpc_pkg::HPC_ST_LIVE;
            hpc_pkg::HPC_MODE_CAL:
            begin
              next_st.cal_start = 1'b1;
              next_st.fsm = hpc_pkg::HPC_ST_PLAY;
            end
            hpc_pkg::HPC_MODE_DIAG:
            begin
              next_st.diag_start = 1'b1;
              next_st.fsm = hpc_pkg::HPC_ST_PLAY;
            end
            default: next_st.fsm = hpc_pkg::HPC_ST_IDLE;
          endcase
        end
      end
      hpc_pkg::HPC_ST_LOAD:
      begin
        if (cur_slot[6:0] == 7'h0)
        begin
          next_st.fsm = hpc_pkg::HPC_ST_IDLE;
          next_st.fire = 1'b0;
        end
        else if (cur_slot[7])
        begin
          next_st.waiting = 1'b1;
          next_st.wait_left = cur_slot[6:0];
          next_st.ms_sub = 4'h0;
          next_st.fsm = hpc_pkg::HPC_ST_PLAY;
        end
        else
        begin
          next_st.waiting = 1'b0;
          next_st.effect.start = 1'b1;
          next_st.effect.id = cur_slot[6:0];
          next_st.fsm = hpc_pkg::HPC_ST_PLAY;
        end
      end
      hpc_pkg::HPC_ST_PLAY:
      begin
        if (st.run_mode == hpc_pkg::HPC_MODE_CAL && cal_done
            || st.run_mode == hpc_pkg::HPC_MODE_DIAG && diag_done)
        begin
          next_st.fsm = hpc_pkg::HPC_ST_IDLE;
          next_st.fire = 1'b0;
        end
        else if (st.run_mode == hpc_pkg::HPC_MODE_SEQ)
        begin
          if (!st.waiting && step_pulse)
          begin
            // library samples advance on the playback interval
            next_st.drive = signed'(scaled[9:2]);
            next_st.drive_valid = 1'b1;
          end
          // wait slots count 10 ms units on the 1 ms/5 ms step: tracked in ms
          if (st.waiting && step_pulse)
          begin
            if (st.ms_sub + (st.interval_fast ? 4'h1 : 4'h5) >= 4'(`HPC_WAIT_UNIT_MS))
            begin
              next_st.ms_sub = 4'h0;
              next_st.wait_left = st.wait_left - 7'h1;
            end
            else
            begin
              next_st.ms_sub = st.ms_sub + (st.interval_fast ? 4'h1 : 4'h5);
            end
          end
          if (st.waiting ? (st.wait_left == 7'h0) : effect_done)
          begin
            if (st.slot_idx == 3'(NSLOTS - 1))
            begin
              next_st.fsm = hpc_pkg::HPC_ST_IDLE;
              next_st.fire = 1'b0;
            end
            else
            begin
              next_st.slot_idx = st.slot_idx + 3'h1;
              next_st.fsm = hpc_pkg::HPC_ST_LOAD;
            end
          end
        end
      end
      hpc_pkg::HPC_ST_LIVE:
      begin
        // live value bypasses attenuation and follows every write
        next_st.drive = signed'(next_st.live_drive_amplitude);
        next_st.drive_valid = 1'b1;
      end
      default: next_st.fsm = hpc_pkg::HPC_ST_IDLE;
    endcase
    // a write of one while running is ignored by the idle-only start above
    if (fire_clear && st.fsm != hpc_pkg::HPC_ST_IDLE && !trigger)
    begin
      next_st.fsm = hpc_pkg::HPC_ST_IDLE;
      next_st.fire = 1'b0;
      next_st.abort = 1'b1;
      next_st.drive = 8'sh0;
    end
  end

  // =========================================================
  // state register: documented reset values, everything else clears
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
      st.live_drive_amplitude <= `HPC_LIVE_RESET;
      st.slot <= {NSLOTS{`HPC_SLOT_RESET}};
    end
    else
    begin
      st <= next_st;
    end
  end

  // =========================================================
  // outputs straight from flip-flops, so the engines see no glitches
  assign rdata = st.rdata;
  assign rvalid = st.rvalid;
  assign cal_start = st.cal_start;
  assign diag_start = st.diag_start;
  assign effect = st.effect;
  assign abort = st.abort;
  assign drive = st.drive;
  assign drive_valid = st.drive_valid;
  assign step = step_pulse;

endmodule : hpc_playback_ctrl

// >>> verification/hpc_engine_model.sv
// engine stand-in: answers each start pulse with a done pulse after a set delay
`timescale 1ns/1ps
module hpc_engine_model
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // starts and cancel
  input wire logic cal_start,
  input wire logic diag_start,
  input wire logic effect_start,
  input wire logic abort,
  input wire logic [15:0] delay,
  // completion
  output logic cal_done,
  output logic diag_done,
  output logic effect_done
);
  // ====
  // one job at a time; a cancel drops it so no stale done follows
  logic [2:0] kind;
  logic [15:0] cnt;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      kind <= 3'h0;
      cnt <= 16'h0;
    end
    else if (abort)
      kind <= 3'h0;
    else if (cal_start | diag_start | effect_start)
    begin
      kind <= {cal_start, diag_start, effect_start};
      cnt <= delay;
    end
    else if (cnt != 16'h0)
      cnt <= cnt - 16'h1;
  end
  assign cal_done = kind[2] && cnt == 16'h1;
  assign diag_done = kind[1] && cnt == 16'h1;
  assign effect_done = kind[0] && cnt == 16'h1;
endmodule : hpc_engine_model

// >>> verification/hpc_playback_ctrl_asserts.sv
// port checks of the playback control block
`timescale 1ns/1ps
module hpc_playback_ctrl_asserts
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register access
  input hpc_pkg::hpc_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  // mode and engines
  input wire logic [1:0] mode,
  input wire logic cal_start,
  input wire logic diag_start,
  input hpc_pkg::hpc_effect_t effect,
  input wire logic abort,
  // drive
  input wire logic signed [7:0] drive,
  input wire logic drive_valid,
  input wire logic step
);
  // ====
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic clr;
  assign clr = req.wr && req.addr == 8'h0c && !req.wdata[0];
  sequence live_wr_s;
    mode == 2'h0 && drive_valid && req.wr && req.addr == 8'h0e;
  endsequence
  sequence live_next_s;
    mode != 2'h0 || drive == $past(req.wdata);
  endsequence
  rd_answer_a: assert property (req.rd |=> rvalid) else $error("read unanswered");
  rvalid_cause_a: assert property (rvalid |-> $past(req.rd)) else $error("stray rvalid");
  unmapped_zero_a: assert property (req.rd && req.addr > 8'h16 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  cal_mode_a: assert property (cal_start |-> mode == 2'h3) else $error("cal in bad mode");
  diag_mode_a: assert property (diag_start |-> mode == 2'h2) else $error("diag bad mode");
  seq_mode_a: assert property (effect.start |-> mode == 2'h1 && effect.id != 7'h00)
    else $error("bad effect start");
  abort_cause_a: assert property (abort |-> $past(clr) || $past(clr, 2))
    else $error("abort without clear");
  abort_quiet_a: assert property (abort |-> ##[0:1] drive == 8'h00) else $error("drive on");
  live_follow_a: assert property (live_wr_s |=> live_next_s) else $error("live lag");
  step_pulse_a: assert property (step |=> !step) else $error("step too long");
  start_pulse_a: assert property (effect.start |=> !effect.start) else $error("long start");
endmodule : hpc_playback_ctrl_asserts
bind hpc_playback_ctrl hpc_playback_ctrl_asserts hpc_playback_ctrl_asserts_i (.clk, .resetn,
  .req, .rdata, .rvalid, .mode, .cal_start, .diag_start, .effect, .abort, .drive,
  .drive_valid, .step);

// >>> verification/tb_haptic_playback_control.sv
// register-level bench of the playback control block
`timescale 1ns/1ps
module tb_haptic_playback_control;
  // ====
  logic clk, resetn, rvalid, trigger, abort, drive_valid, step, cal_start, diag_start;
  logic cal_done, diag_done, effect_done;
  logic [1:0] mode;
  logic [7:0] rdata;
  logic [15:0] delay;
  logic signed [7:0] library_sample, drive;
  hpc_pkg::hpc_req_t req;
  hpc_pkg::hpc_effect_t effect;
  logic [6:0] ids[$];
  int n_fail = 0, n_compared = 0, n_start = 0, cyc = 0;
  hpc_playback_ctrl hpc_playback_ctrl_i (.clk(clk), .resetn(resetn), .req(req),
    .rdata(rdata), .rvalid(rvalid), .mode(mode), .trigger(trigger), .cal_start(cal_start),
    .cal_done(cal_done), .diag_start(diag_start), .diag_done(diag_done), .effect(effect),
    .effect_done(effect_done), .abort(abort), .library_sample(library_sample),
    .drive(drive), .drive_valid(drive_valid), .step(step));
  hpc_engine_model hpc_engine_model_i (.clk(clk), .resetn(resetn), .cal_start(cal_start),
    .diag_start(diag_start), .effect_start(effect.start), .abort(abort), .delay(delay),
    .cal_done(cal_done), .diag_done(diag_done), .effect_done(effect_done));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic print_verdict;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // the whole run needs about 50150 cycles, mostly one 1 ms step
  always @(posedge clk)
  begin
    cyc++;
    if (effect.start === 1'b1)
      ids.push_back(effect.id);
    if (cal_start === 1'b1 || diag_start === 1'b1)
      n_start++;
    if (cyc == 60000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc_n
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    cyc_n(1);
    req = '0;
    // one idle edge so that a following call never rewrites req in the same time step
    cyc_n(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req = '{1'b0, 1'b1, a, 8'h00};
    cyc_n(1);
    req = '0;
    chk({7'h0, rvalid}, 8'h01);
    chk(rdata, exp);
    cyc_n(1);
  endtask : rd
  initial
  begin
    req = '0;
    mode = 2'h0;
    trigger = 1'b0;
    library_sample = 8'sh40;
    delay = 16'd6;
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    #1 resetn = 1'b1;
    rd(8'h0c, 8'h00);
    rd(8'h0d, 8'h00);
    rd(8'h0e, 8'h7f);
    rd(8'h30, 8'h00);
    wr(8'h0d, 8'h03);
    wr(8'h0e, 8'h80);
    wr(8'h0c, 8'h01);
    cyc_n(3);
    chk(drive, 8'h80);
    chk({7'h0, drive_valid}, 8'h01);
    wr(8'h0e, 8'h15);
    cyc_n(1);
    chk(drive, 8'h15);
    rd(8'h0c, 8'h01);
    wr(8'h0c, 8'h00);
    cyc_n(2);
    rd(8'h0c, 8'h00);
    for (int m = 2; m < 4; m++)
    begin
      mode = m[1:0];
      trigger = (m == 2);
      req.wr = (m == 3);
      req.addr = 8'h0c;
      req.wdata = 8'h01;
      cyc_n(1);
      trigger = 1'b0;
      req = '0;
      cyc_n(2);
      rd(8'h0c, 8'h01);
      wr(8'h0c, 8'h01);
      cyc_n(12);
      rd(8'h0c, 8'h00);
      chk(8'(n_start), 8'(m - 1));
    end
    mode = 2'h1;
    wr(8'h0f, 8'h05);
    wr(8'h10, 8'h06);
    wr(8'h11, 8'h00);
    wr(8'h0c, 8'h01);
    cyc_n(40);
    rd(8'h0c, 8'h00);
    chk(8'(ids.size()), 8'h02);
    chk({1'b0, ids[0]}, 8'h05);
    chk({1'b0, ids[1]}, 8'h06);
    delay = 16'hffff;
    wr(8'h0d, 8'h21);
    wr(8'h0f, 8'h03);
    wr(8'h10, 8'h00);
    wr(8'h0c, 8'h01);
    for (int i = 0; i < 52000 && step !== 1'b1; i++)
      cyc_n(1);
    cyc_n(1);
    chk(drive, 8'h30);
    wr(8'h0c, 8'h00);
    cyc_n(2);
    chk(drive, 8'h00);
    rd(8'h0c, 8'h00);
    print_verdict();
  end
endmodule : tb_haptic_playback_control
